/* common/psr_defs.svh */
// Register offsets, field positions, reset values and timing counts of the platform system registers
`ifndef PSR_DEFS_SVH
`define PSR_DEFS_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define PSR_OFF_IDENT       8'h00
`define PSR_OFF_SWITCH      8'h04
`define PSR_OFF_LED         8'h08
`define PSR_OFF_SLOW_CNT    8'h24
`define PSR_OFF_FLAGS       8'h30
`define PSR_OFF_FLAGS_CLR   8'h34
`define PSR_OFF_RFLAGS      8'h38
`define PSR_OFF_RFLAGS_CLR  8'h3C
`define PSR_OFF_CARD        8'h48
`define PSR_OFF_FLASH       8'h4C
`define PSR_OFF_BOOT_SW     8'h58
`define PSR_OFF_FAST_CNT    8'h5C
`define PSR_OFF_MISC        8'h60
`define PSR_OFF_DMA         8'h64
`define PSR_OFF_PROC0       8'h84
`define PSR_OFF_PROC1       8'h88
`define PSR_OFF_PROC2       8'h8C
`define PSR_OFF_PROC3       8'h90
`define PSR_OFF_XDATA       8'hA0
`define PSR_OFF_XCTRL       8'hA4
`define PSR_OFF_XSTAT       8'hA8

// ----------------------------------------------------------------
// Transfer control and status fields
// ----------------------------------------------------------------
`define PSR_CTRL_START      31
`define PSR_CTRL_WRITE      30
`define PSR_CTRL_FUNC_HI    25
`define PSR_CTRL_FUNC_LO    20
`define PSR_CTRL_SITE_HI    17
`define PSR_CTRL_SITE_LO    16
`define PSR_STAT_DONE       0
`define PSR_STAT_ERR        1
`define PSR_FUNC_SHUTDOWN   6'h08

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define PSR_RST_WORD        32'h0000_0000
`define PSR_RST_IDENT       32'h1234_5678
`define PSR_SITE_MAX        2'h2
`define PSR_SITE_DEFAULT    2'h1

// ----------------------------------------------------------------
// Timing: clock rate and counter rates
// ----------------------------------------------------------------
`define PSR_CLK_HZ          100000000
`define PSR_SLOW_HZ         100
`define PSR_SLOW_DIV        (`PSR_CLK_HZ / `PSR_SLOW_HZ)
`define PSR_FAST_MHZ        24
`define PSR_CLK_MHZ         100

`endif

/* common/psr_pkg.sv */
// Types shared by the platform system register modules
package psr_pkg;

   // Transfer engine states
   typedef enum logic [1:0] {
      PSR_X_IDLE,
      PSR_X_REQ,
      PSR_X_DONE
   } psr_xstate_t;

   // Board sites
   typedef enum logic [1:0] {
      PSR_MAIN_BOARD_SITE,
      PSR_DAUGHTERBOARD_ONE_SITE,
      PSR_DAUGHTERBOARD_TWO_SITE
   } psr_site_t;

   typedef logic [31:0] psr_word_t;

endpackage : psr_pkg

/* common/psr_xfer_if.sv */
// Carrier between the register bank and its board transfer engine
`timescale 1ns/1ps
interface psr_xfer_if;
   import psr_pkg::*;

   logic       start;      // One-cycle start pulse
   logic       write;      // Direction: 1 = send to controller
   logic [5:0] func;       // Selected function
   logic [1:0] site;       // Target board site
   psr_word_t  wdata;      // Word to send
   logic       busy;       // Transfer in flight
   logic       done;       // One-cycle completion pulse
   logic       err;        // Error flag, valid with done
   psr_word_t  rdata;      // Returned word, valid with done

   modport bank (output start, write, func, site, wdata, input busy, done, err, rdata);
   modport engine (input start, write, func, site, wdata, output busy, done, err, rdata);
endinterface : psr_xfer_if

/* logic/psr_sync.sv */
// Three-stage pin synchroniser; a change counts once stages two and three agree
`timescale 1ns/1ps
module psr_sync #(
   parameter int W = 8
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst,
   // Pin side
   input  wire logic [W-1:0] pin_in,
   // Clock domain side
   output logic      [W-1:0] level_out
);

   logic [W-1:0] s1_reg, s2_reg, s3_reg, lvl_reg;   // Stages and accepted level
   logic [W-1:0] lvl_next;

   // ----------------------------------------------------------------
   // Accept per bit only where stages two and three agree
   // ----------------------------------------------------------------
   always_comb begin
      for (int i = 0; i < W; i++) begin
         lvl_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : lvl_reg[i];
      end
   end

   // Stage one is read only by stage two, to keep metastability contained
   always_ff @(posedge clk) begin
      if (rst) begin
         s1_reg  <= '0;
         s2_reg  <= '0;
         s3_reg  <= '0;
         lvl_reg <= '0;
      end else begin
         s1_reg  <= pin_in;
         s2_reg  <= s1_reg;
         s3_reg  <= s2_reg;
         lvl_reg <= lvl_next;
      end
   end

   assign level_out = lvl_reg;

endmodule : psr_sync

/* logic/psr_top.sv */
// Platform system register bank: identity, switches, LEDs, flags, counters, board transfer
//
// Behaviour
// - Switch register shows eight switch positions
// - LED register drives LEDs, reads back
// - Flag clear write clears matching flag bits
// - Retained clear write clears matching retained bits
// - Data register sends and receives transfer words
// - Control write starts transfer with selected function
// - Status register reports transfer outcome, read/write
// - Shutdown function halts platform when enabled
// - Board site selects 0..2, defaults 1
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
`include "psr_defs.svh"
module psr_top
   import psr_pkg::*;
#(
   parameter psr_word_t  IDENT_VALUE      = `PSR_RST_IDENT,   // Arbitrary identity value
   parameter bit         EXIT_ON_SHUTDOWN = 1'b0,
   parameter logic [1:0] SITE_DEFAULT     = `PSR_SITE_DEFAULT,
   parameter int         SLOW_DIV         = `PSR_SLOW_DIV,    // Clocks per slow tick
   parameter int         FAST_NUM         = `PSR_FAST_MHZ,    // Fast ticks per FAST_DEN clocks
   parameter int         FAST_DEN         = `PSR_CLK_MHZ
) (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // Register port
   input  wire logic [7:0] addr,
   input  wire psr_word_t  wdata,
   input  wire logic       wr,
   input  wire logic       rd,
   output psr_word_t       rdata,
   // Board pins
   input  wire logic [7:0] user_switch_bank,
   output logic      [7:0] user_led,
   output logic            shutdown,
   // Motherboard controller
   output logic            mb_req,
   output logic            mb_write,
   output logic [5:0]      mb_func,
   output logic [1:0]      mb_site,
   output psr_word_t       mb_wdata,
   input  wire logic       mb_ack,
   input  wire logic       mb_err,
   input  wire psr_word_t  mb_rdata
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   psr_xfer_if xf ();                                // Link to transfer engine

   logic [7:0]  sw_level;                            // Synchronised switches
   psr_word_t   ident_reg, ident_next;               // Identity
   logic [7:0]  led_reg, led_next;                   // LED drive
   psr_word_t   flags_reg, flags_next;               // General flags
   psr_word_t   rflags_reg, rflags_next;             // Retained flags
   psr_word_t   flash_reg, flash_next;
   psr_word_t   bootsw_reg, bootsw_next;
   psr_word_t   misc_reg, misc_next;
   psr_word_t   dma_reg, dma_next;
   psr_word_t   proc_reg [4];                        // Processor identity words
   psr_word_t   proc_next [4];
   psr_word_t   xdata_reg, xdata_next;               // Transfer data
   psr_word_t   xctrl_reg, xctrl_next;               // Transfer control
   logic [1:0]  xstat_reg, xstat_next;               // Done and error bits
   logic        shut_reg, shut_next;
   psr_word_t   rdata_reg, rdata_next;
   logic [31:0] slow_div_reg, slow_div_next;         // Divider towards 100 Hz
   logic [7:0]  fast_acc_reg, fast_acc_next;         // Fractional accumulator towards 24 MHz
   psr_word_t   slow_cnt_reg, slow_cnt_next;
   psr_word_t   fast_cnt_reg, fast_cnt_next;
   logic        start_pulse;                         // Accepted start request
   logic [1:0]  site_sel;                            // Validated site field
   logic [7:0]  fast_sum;

   // ----------------------------------------------------------------
   // Submodules
   // ----------------------------------------------------------------
   psr_sync #(.W(8)) u_sw_sync (
      .clk       (clk),
      .rst       (rst),
      .pin_in    (user_switch_bank),
      .level_out (sw_level)
   );

   psr_xfer u_xfer (
      .clk      (clk),
      .rst      (rst),
      .xf       (xf),
      .mb_req   (mb_req),
      .mb_write (mb_write),
      .mb_func  (mb_func),
      .mb_site  (mb_site),
      .mb_wdata (mb_wdata),
      .mb_ack   (mb_ack),
      .mb_err   (mb_err),
      .mb_rdata (mb_rdata)
   );

   // ----------------------------------------------------------------
   // Transfer request decode
   // ----------------------------------------------------------------
   // A start while a transfer is in flight is dropped, so a stale word cannot overtake
   always_comb begin
      start_pulse = wr && (addr == `PSR_OFF_XCTRL) && wdata[`PSR_CTRL_START] && !xf.busy;
      site_sel    = wdata[`PSR_CTRL_SITE_HI:`PSR_CTRL_SITE_LO];
      if (site_sel > `PSR_SITE_MAX) begin
         site_sel = SITE_DEFAULT;                    // Out of range falls back to default
      end
   end

   assign xf.start = start_pulse;
   assign xf.write = wdata[`PSR_CTRL_WRITE];
   assign xf.func  = wdata[`PSR_CTRL_FUNC_HI:`PSR_CTRL_FUNC_LO];
   assign xf.site  = site_sel;
   assign xf.wdata = xdata_reg;

   // ----------------------------------------------------------------
   // Counters
   // ----------------------------------------------------------------
   // Fast rate is not an integer divisor of the clock, so an accumulator spreads its ticks
   always_comb begin
      slow_div_next = slow_div_reg + 32'h0000_0001;
      slow_cnt_next = slow_cnt_reg;
      if (slow_div_reg == 32'(SLOW_DIV - 1)) begin
         slow_div_next = 32'h0000_0000;
         slow_cnt_next = slow_cnt_reg + 32'h0000_0001;
      end
      fast_sum      = fast_acc_reg + 8'(FAST_NUM);
      fast_acc_next = fast_sum;
      fast_cnt_next = fast_cnt_reg;
      if (fast_sum >= 8'(FAST_DEN)) begin
         fast_acc_next = fast_sum - 8'(FAST_DEN);
         fast_cnt_next = fast_cnt_reg + 32'h0000_0001;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         slow_div_reg <= 32'h0000_0000;
         fast_acc_reg <= 8'h00;
         slow_cnt_reg <= `PSR_RST_WORD;
         fast_cnt_reg <= `PSR_RST_WORD;
      end else begin
         slow_div_reg <= slow_div_next;
         fast_acc_reg <= fast_acc_next;
         slow_cnt_reg <= slow_cnt_next;
         fast_cnt_reg <= fast_cnt_next;
      end
   end

   // ----------------------------------------------------------------
   // Register writes and transfer status
   // ----------------------------------------------------------------
   always_comb begin
      ident_next  = ident_reg;
      led_next    = led_reg;
      flags_next  = flags_reg;
      rflags_next = rflags_reg;
      flash_next  = flash_reg;
      bootsw_next = bootsw_reg;
      misc_next   = misc_reg;
      dma_next    = dma_reg;
      proc_next   = proc_reg;
      xdata_next  = xdata_reg;
      xctrl_next  = xctrl_reg;
      xstat_next  = xstat_reg;
      shut_next   = shut_reg;
      if (wr) begin
         case (addr)
            `PSR_OFF_IDENT:      ident_next  = wdata;
            `PSR_OFF_LED:        led_next    = wdata[7:0];
            `PSR_OFF_FLAGS:      flags_next  = wdata;
            `PSR_OFF_FLAGS_CLR:  flags_next  = flags_reg & ~wdata;
            `PSR_OFF_RFLAGS:     rflags_next = wdata;
            `PSR_OFF_RFLAGS_CLR: rflags_next = rflags_reg & ~wdata;
            `PSR_OFF_FLASH:      flash_next  = wdata;
            `PSR_OFF_BOOT_SW:    bootsw_next = wdata;
            `PSR_OFF_MISC:       misc_next   = wdata;
            `PSR_OFF_DMA:        dma_next    = wdata;
            `PSR_OFF_PROC0:      proc_next[0] = wdata;
            `PSR_OFF_PROC1:      proc_next[1] = wdata;
            `PSR_OFF_PROC2:      proc_next[2] = wdata;
            `PSR_OFF_PROC3:      proc_next[3] = wdata;
            `PSR_OFF_XDATA:      xdata_next  = wdata;
            `PSR_OFF_XCTRL: begin
               xctrl_next = wdata;
               xctrl_next[`PSR_CTRL_START] = start_pulse || xf.busy;    // Start reads as in flight
               xctrl_next[`PSR_CTRL_SITE_HI:`PSR_CTRL_SITE_LO] = site_sel;
            end
            `PSR_OFF_XSTAT:      xstat_next  = wdata[1:0];
            default: begin
               // Read-only and unmapped offsets ignore writes
            end
         endcase
      end
      if (start_pulse) begin
         xstat_next = 2'b00;                         // New transfer clears old outcome
         if (EXIT_ON_SHUTDOWN && xf.func == `PSR_FUNC_SHUTDOWN) begin
            shut_next = 1'b1;
         end
      end
      if (xf.done) begin                             // Hardware set wins over software write
         xctrl_next[`PSR_CTRL_START] = 1'b0;
         xstat_next[`PSR_STAT_DONE]  = 1'b1;
         xstat_next[`PSR_STAT_ERR]   = xf.err;
         if (!mb_write) begin                        // Latched direction
            xdata_next = xf.rdata;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         ident_reg  <= IDENT_VALUE;
         led_reg    <= 8'h00;
         flags_reg  <= `PSR_RST_WORD;
         rflags_reg <= `PSR_RST_WORD;
         flash_reg  <= `PSR_RST_WORD;
         bootsw_reg <= `PSR_RST_WORD;
         misc_reg   <= `PSR_RST_WORD;
         dma_reg    <= `PSR_RST_WORD;
         for (int i = 0; i < 4; i++) begin
            proc_reg[i] <= `PSR_RST_WORD;
         end
         xdata_reg  <= `PSR_RST_WORD;
         xctrl_reg  <= {14'h0000, SITE_DEFAULT, 16'h0000};
         xstat_reg  <= 2'b00;
         shut_reg   <= 1'b0;
      end else begin
         ident_reg  <= ident_next;
         led_reg    <= led_next;
         flags_reg  <= flags_next;
         rflags_reg <= rflags_next;
         flash_reg  <= flash_next;
         bootsw_reg <= bootsw_next;
         misc_reg   <= misc_next;
         dma_reg    <= dma_next;
         proc_reg   <= proc_next;
         xdata_reg  <= xdata_next;
         xctrl_reg  <= xctrl_next;
         xstat_reg  <= xstat_next;
         shut_reg   <= shut_next;
      end
   end

   // ----------------------------------------------------------------
   // Read path: data stand in the cycle after the strobe only
   // ----------------------------------------------------------------
   always_comb begin
      rdata_next = `PSR_RST_WORD;                    // Idle and unmapped read as zero
      if (rd) begin
         case (addr)
            `PSR_OFF_IDENT:    rdata_next = ident_reg;
            `PSR_OFF_SWITCH:   rdata_next = {24'h000000, sw_level};
            `PSR_OFF_LED:      rdata_next = {24'h000000, led_reg};
            `PSR_OFF_SLOW_CNT: rdata_next = slow_cnt_reg;
            `PSR_OFF_FLAGS:    rdata_next = flags_reg;
            `PSR_OFF_RFLAGS:   rdata_next = rflags_reg;
            `PSR_OFF_FLASH:    rdata_next = flash_reg;
            `PSR_OFF_BOOT_SW:  rdata_next = bootsw_reg;
            `PSR_OFF_FAST_CNT: rdata_next = fast_cnt_reg;
            `PSR_OFF_MISC:     rdata_next = misc_reg;
            `PSR_OFF_DMA:      rdata_next = dma_reg;
            `PSR_OFF_PROC0:    rdata_next = proc_reg[0];
            `PSR_OFF_PROC1:    rdata_next = proc_reg[1];
            `PSR_OFF_PROC2:    rdata_next = proc_reg[2];
            `PSR_OFF_PROC3:    rdata_next = proc_reg[3];
            `PSR_OFF_XDATA:    rdata_next = xdata_reg;
            `PSR_OFF_XCTRL:    rdata_next = xctrl_reg;
            `PSR_OFF_XSTAT:    rdata_next = {30'h00000000, xstat_reg};
            default:           rdata_next = `PSR_RST_WORD;  // Clear regs and card status read zero
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rdata_reg <= `PSR_RST_WORD;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign rdata    = rdata_reg;
   assign user_led = led_reg;
   assign shutdown = shut_reg;

endmodule : psr_top

/* logic/psr_xfer.sv */
// Board transfer engine: request/acknowledge exchange with the motherboard controller
`timescale 1ns/1ps
`include "psr_defs.svh"
module psr_xfer
   import psr_pkg::*;
(
   // Clock and reset
   input  wire logic  clk,
   input  wire logic  rst,
   // Register bank side
   psr_xfer_if.engine xf,
   // Controller side
   output logic       mb_req,
   output logic       mb_write,
   output logic [5:0] mb_func,
   output logic [1:0] mb_site,
   output psr_word_t  mb_wdata,
   input  wire logic  mb_ack,
   input  wire logic  mb_err,
   input  wire psr_word_t mb_rdata
);

   psr_xstate_t st_reg, st_next;                    // Engine state
   logic        req_reg, req_next;                  // Request level to controller
   logic        wr_reg, wr_next;
   logic [5:0]  fn_reg, fn_next;
   logic [1:0]  site_reg, site_next;
   psr_word_t   wd_reg, wd_next, rd_reg, rd_next;
   logic        err_reg, err_next;

   // ----------------------------------------------------------------
   // Next state: hold request until acknowledged, then report once
   // ----------------------------------------------------------------
   always_comb begin
      st_next   = st_reg;
      req_next  = req_reg;
      wr_next   = wr_reg;
      fn_next   = fn_reg;
      site_next = site_reg;
      wd_next   = wd_reg;
      rd_next   = rd_reg;
      err_next  = err_reg;
      case (st_reg)
         PSR_X_IDLE: begin
            if (xf.start) begin                     // Latch request fields
               st_next   = PSR_X_REQ;
               req_next  = 1'b1;
               wr_next   = xf.write;
               fn_next   = xf.func;
               site_next = xf.site;
               wd_next   = xf.wdata;
            end
         end
         PSR_X_REQ: begin
            if (mb_ack) begin                       // Controller answered
               st_next  = PSR_X_DONE;
               req_next = 1'b0;
               err_next = mb_err;
               rd_next  = mb_rdata;
            end
         end
         PSR_X_DONE: begin
            st_next = PSR_X_IDLE;                   // Done pulse lasts this cycle
         end
         default: begin
            st_next  = PSR_X_IDLE;
            req_next = 1'b0;
         end
      endcase
   end

   // Register stage
   always_ff @(posedge clk) begin
      if (rst) begin
         st_reg   <= PSR_X_IDLE;
         req_reg  <= 1'b0;
         wr_reg   <= 1'b0;
         fn_reg   <= 6'h00;
         site_reg <= `PSR_SITE_DEFAULT;
         wd_reg   <= `PSR_RST_WORD;
         rd_reg   <= `PSR_RST_WORD;
         err_reg  <= 1'b0;
      end else begin
         st_reg   <= st_next;
         req_reg  <= req_next;
         wr_reg   <= wr_next;
         fn_reg   <= fn_next;
         site_reg <= site_next;
         wd_reg   <= wd_next;
         rd_reg   <= rd_next;
         err_reg  <= err_next;
      end
   end

   // Outputs
   assign xf.busy  = (st_reg != PSR_X_IDLE);
   assign xf.done  = (st_reg == PSR_X_DONE);
   assign xf.err   = err_reg;
   assign xf.rdata = rd_reg;
   assign mb_req   = req_reg;
   assign mb_write = wr_reg;
   assign mb_func  = fn_reg;
   assign mb_site  = site_reg;
   assign mb_wdata = wd_reg;

endmodule : psr_xfer

/* verification/psr_mb_model.sv */
// Motherboard controller model answering board transfers
`timescale 1ns/1ps
module psr_mb_model
   import psr_pkg::*;
(
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // Request from the bank
   input  wire logic       mb_req,
   input  wire logic       mb_write,
   input  wire logic [5:0] mb_func,
   input  wire logic [1:0] mb_site,
   input  wire psr_word_t  mb_wdata,
   // Answer to the bank
   output logic            mb_ack,
   output logic            mb_err,
   output psr_word_t       mb_rdata,
   // Bench control and request record
   input  wire logic [3:0] lat,
   input  wire logic       err_in,
   input  wire psr_word_t  word_in,
   output logic [8:0]      seen,
   output psr_word_t       seen_w
);
   int cnt;   // Cycles waited on the current request
   // Answer after lat cycles; lines toggle elsewhere so stale data never looks valid
   always @(posedge clk) begin
      mb_ack <= 1'b0;
      mb_err <= ~mb_err;
      mb_rdata <= ~mb_rdata;
      if (rst) begin
         cnt <= 0;
         mb_err <= 1'b0;
         mb_rdata <= 32'h0;
      end else if (mb_req && !mb_ack) begin
         if (cnt >= lat) begin
            mb_ack <= 1'b1;
            mb_err <= err_in;
            mb_rdata <= word_in;
            seen <= {mb_write, mb_func, mb_site};
            seen_w <= mb_wdata;
            cnt <= 0;
         end else cnt <= cnt + 1;
      end
   end
endmodule : psr_mb_model

/* verification/psr_top_sva.sv */
// Concurrent checks on the bank's ports
`timescale 1ns/1ps
module psr_top_sva
   import psr_pkg::*;
#(
   parameter bit EXIT_ON_SHUTDOWN = 1'b0
) (
   // Clock and reset
   input wire logic       clk,
   input wire logic       rst,
   // Register port
   input wire logic [7:0] addr,
   input wire psr_word_t  wdata,
   input wire logic       wr,
   input wire logic       rd,
   input wire psr_word_t  rdata,
   // Pins and controller side
   input wire logic [7:0] user_led,
   input wire logic       shutdown,
   input wire logic       mb_req,
   input wire logic       mb_write,
   input wire logic [5:0] mb_func,
   input wire logic [1:0] mb_site,
   input wire psr_word_t  mb_wdata,
   input wire logic       mb_ack
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   property p_led; wr && addr == 8'h08 |=> user_led == $past(wdata[7:0]); endproperty
   property p_led_hold; !(wr && addr == 8'h08) |=> $stable(user_led); endproperty
   property p_led_read; rd && addr == 8'h08 |=> rdata[7:0] == user_led; endproperty
   property p_req_cause; $rose(mb_req) |-> $past(wr && addr == 8'hA4 && wdata[31]); endproperty
   property p_req_fields; $rose(mb_req) |-> {mb_write, mb_func} == $past({wdata[30], wdata[25:20]}); endproperty
   property p_req_hold; mb_req && !mb_ack |=> mb_req && $stable({mb_write, mb_func, mb_site, mb_wdata}); endproperty
   property p_req_end; mb_req && mb_ack |=> !mb_req; endproperty
   property p_site; mb_site <= 2'h2; endproperty
   property p_shut; shutdown |-> EXIT_ON_SHUTDOWN; endproperty
   a_led: assert property (p_led) else $error("led value");
   a_led_hold: assert property (p_led_hold) else $error("led moved");
   a_led_read: assert property (p_led_read) else $error("led read");
   a_req_cause: assert property (p_req_cause) else $error("stray request");
   a_req_fields: assert property (p_req_fields) else $error("request fields");
   a_req_hold: assert property (p_req_hold) else $error("request moved");
   a_req_end: assert property (p_req_end) else $error("request held");
   a_site: assert property (p_site) else $error("site range");
   a_shut: assert property (p_shut) else $error("stray shutdown");
   // Scenarios reached
   c_start: cover property ($rose(mb_req));
   c_ack: cover property (mb_req && mb_ack);
   c_clear: cover property (wr && addr == 8'h34);
endmodule : psr_top_sva

/* verification/psr_top_test.sv */
// Self-checking bench for the system register bank
`timescale 1ns/1ps
`include "psr_defs.svh"
module psr_top_test;
   import psr_pkg::*;
   logic clk = 0, rst = 1, wr = 0, rd = 0, err_in = 0, mb_req, mb_write, mb_ack, mb_err, shutdown;
   logic [7:0] addr = 0, sw = 0, led, o;
   logic [5:0] mb_func, func;
   logic [1:0] mb_site, site;
   logic [3:0] lat = 4'h3;
   logic [8:0] seen;
   psr_word_t wdata = 0, word_in = 0, rdata, mb_wdata, mb_rdata, seen_w, got, a, b, r, s0, f0, s1, f1;
   logic [31:0] seed = 32'ha634b25f;   // Fixed seed keeps runs repeatable
   int mismatches = 0, n_checks = 0;
   always #5 clk = ~clk;
   psr_top #(.SLOW_DIV(10)) psr_top_inst (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .user_switch_bank(sw), .user_led(led), .shutdown(shutdown), .mb_req(mb_req),
      .mb_write(mb_write), .mb_func(mb_func), .mb_site(mb_site), .mb_wdata(mb_wdata), .mb_ack(mb_ack),
      .mb_err(mb_err), .mb_rdata(mb_rdata));
   psr_mb_model psr_mb_model_inst (.clk(clk), .rst(rst), .mb_req(mb_req), .mb_write(mb_write),
      .mb_func(mb_func), .mb_site(mb_site), .mb_wdata(mb_wdata), .mb_ack(mb_ack), .mb_err(mb_err),
      .mb_rdata(mb_rdata), .lat(lat), .err_in(err_in), .word_in(word_in), .seen(seen), .seen_w(seen_w));
   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   task automatic check(input psr_word_t v, input psr_word_t e);
      n_checks++;
      if (v !== e) begin
         mismatches++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, v, e);
      end
   endtask : check
   // One-cycle strobes, changed right after the edge
   task automatic wr_reg(input logic [7:0] ad, input psr_word_t d);
      @(posedge clk); wr <= 1'b1; addr <= ad; wdata <= d;
      @(posedge clk); wr <= 1'b0;
   endtask : wr_reg
   task automatic rd_reg(input logic [7:0] ad, output psr_word_t d);
      @(posedge clk); rd <= 1'b1; addr <= ad;
      @(posedge clk); rd <= 1'b0;
      #1 d = rdata;
   endtask : rd_reg
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : wrap_up
   // Watchdog, well past the run
   initial begin
      #200000; mismatches++; wrap_up();
   end
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      rd_reg(8'h08, got); check(got, 32'h0);
      rd_reg(8'h00, got); check(got, `PSR_RST_IDENT);
      rd_reg(8'hA8, got); check(got, 32'h0);
      rd_reg(8'hFC, got); check(got, 32'h0);
      for (int i = 0; i < 4; i++) begin
         sw <= 8'(rnd());
         repeat (6) @(posedge clk);
         rd_reg(8'h04, got); check(got, {24'h0, sw});
         a = rnd(); wr_reg(8'h08, a);
         rd_reg(8'h08, got); check({24'h0, got[7:0]}, {24'h0, a[7:0]});
         check({24'h0, led}, {24'h0, a[7:0]});
         for (int j = 0; j < 2; j++) begin
            o = j ? 8'h38 : 8'h30; a = rnd(); b = (i == 0) ? '1 : rnd();
            wr_reg(o, a); wr_reg(o + 8'h04, b);
            rd_reg(o, got); check(got, a & ~b);
            rd_reg(o + 8'h04, got); check(got, 32'h0);
         end
      end
      // Counters 100 cycles apart, writes ignored between
      rd_reg(8'h24, s0); rd_reg(8'h5C, f0); wr_reg(8'h24, 32'h0); wr_reg(8'h5C, 32'h0);
      repeat (92) @(posedge clk);
      rd_reg(8'h24, s1); rd_reg(8'h5C, f1);
      check(s1 - s0, 32'hA); check(f1 - f0, 32'h18);
      // Transfers, each with a refused restart
      for (int i = 0; i < 6; i++) begin
         r = rnd(); func = (i == 0) ? `PSR_FUNC_SHUTDOWN : r[5:0]; site = r[9:8];
         lat <= 4'h3 + r[12:10]; err_in <= r[13]; word_in <= rnd(); a = rnd();
         wr_reg(8'hA0, a);
         wr_reg(8'hA4, {1'b1, r[6], 4'h0, func, 2'h0, site, 16'h0});
         wr_reg(8'hA4, {1'b1, ~r[6], 4'h0, ~func, 20'h0});
         for (int k = 0; k < 40 && got[0] !== 1'b1; k++) rd_reg(8'hA8, got);
         check(got, {30'h0, r[13], 1'b1});
         check({23'h0, seen}, {23'h0, r[6], func, (site > 2'h2) ? 2'h1 : site});
         rd_reg(8'hA0, got); check(got, r[6] ? a : word_in);
         if (r[6]) check(seen_w, a);
         check({31'h0, shutdown}, 32'h0);
         got = 32'h0;
      end
      wr_reg(8'hA8, 32'h2); rd_reg(8'hA8, got); check(got, 32'h2);
      wrap_up();
   end
endmodule : psr_top_test
bind psr_top psr_top_sva #(.EXIT_ON_SHUTDOWN(EXIT_ON_SHUTDOWN)) psr_top_sva_inst (.*);
